/* File: tb_top.sv */
// Purpose: Self-checking bench of the type B reader codec
// Assumes: A 48 ns link clock stands in for the carrier
// Notes: Each exchange takes about a millisecond, so the run is long
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tbr_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_tx_valid = 1'b0;
  tbr_byte_t i_tx_data = 8'h0;
  logic i_send = 1'b0;
  tbr_addr_t i_rx_addr = 4'h0;
  logic [1:0] mode = 2'h0;
  logic o_tx_ready, o_busy, o_done, o_ok, o_crc_err, o_frame_err, o_timeout;
  logic o_ask_mod, i_sub_on, i_bpsk_bit, req_ok, turn_ok;
  tbr_len_t o_rx_len;
  tbr_byte_t o_rx_data;
  int rx_n;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  always #24 i_link_clk = ~i_link_clk;
  tbr_reader #(.ANSWER_TIMEOUT_CYC(16'h1000)) dut_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready), .i_send(i_send),
    .o_busy(o_busy), .o_done(o_done), .o_ok(o_ok), .o_crc_err(o_crc_err),
    .o_frame_err(o_frame_err), .o_timeout(o_timeout), .o_rx_len(o_rx_len),
    .i_rx_addr(i_rx_addr), .o_rx_data(o_rx_data), .i_link_clk(i_link_clk),
    .o_ask_mod(o_ask_mod), .i_sub_on(i_sub_on), .i_bpsk_bit(i_bpsk_bit));
  tbr_tag_model tag_u (.i_clk(i_link_clk), .i_mod(o_ask_mod), .o_sub_on(i_sub_on),
    .o_bpsk_bit(i_bpsk_bit), .i_mode(mode), .o_req_ok(req_ok), .o_turn_ok(turn_ok),
    .o_rx_n(rx_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic tbr_byte_t pat(input tbr_byte_t b, input int k);
    return b ^ {k[3:0], k[3:0]};
  endfunction
  // Pushes n bytes back to back, sends, and judges the whole exchange
  task automatic exchange(input int n, input tbr_byte_t base, input logic [1:0] m);
    int w;
    int s;
    s = n > 16 ? 16 : n;
    @(posedge i_sys_clk);
    mode <= m;
    for (int k = 0; k < n; k++) begin
      @(posedge i_sys_clk);
      i_tx_valid <= 1'b1;
      i_tx_data <= pat(base, k);
    end
    @(posedge i_sys_clk);
    i_tx_valid <= 1'b0;
    @(negedge i_sys_clk);
    if (n > 16) chk(8'(o_tx_ready), 8'h0);
    @(posedge i_sys_clk);
    i_send <= 1'b1;
    @(posedge i_sys_clk);
    i_send <= 1'b0;
    @(negedge i_sys_clk);
    chk({6'h0, o_busy, o_tx_ready}, 8'h2);
    w = 0;
    while (o_done !== 1'b1 && w < 300000) begin
      @(negedge i_sys_clk);
      w++;
    end
    chk(8'(w >= 300000), 8'h0);
    chk({4'h0, o_ok, o_crc_err, o_frame_err, o_timeout},
      {4'h0, m == 2'h0, m == 2'h1, m == 2'h3, m == 2'h2});
    chk({6'h0, req_ok, turn_ok}, 8'h3);
    chk(8'(rx_n), 8'(s + 2));
    if (m == 2'h0) begin
      chk(8'(o_rx_len), 8'(s + 2));
      for (int k = 0; k < s; k++) begin
        @(posedge i_sys_clk);
        i_rx_addr <= k[3:0];
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk(o_rx_data, pat(base, k));
      end
    end
  endtask
  initial begin
    repeat (2) @(posedge i_link_clk);
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(negedge i_sys_clk);
    chk({o_tx_ready, o_busy, o_done, o_ok, o_crc_err, o_frame_err, o_timeout, o_ask_mod}, 8'h80);
    chk(o_rx_data, 8'h0);
    @(posedge i_sys_clk);
    i_send <= 1'b1;
    @(posedge i_sys_clk);
    i_send <= 1'b0;
    @(negedge i_sys_clk);
    chk(8'(o_busy), 8'h0);
    exchange(2, 8'ha5, 2'h0);
    exchange(1, 8'h00, 2'h1);
    exchange(17, 8'hff, 2'h2);
    // Last, since the tag keeps talking after the reader gives up on the frame
    exchange(1, 8'h3c, 2'h3);
    finish_test;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 1000000) begin
      errors++;
      finish_test;
    end
  end
endmodule
`default_nettype wire

/* File: tbr_crc.sv */
// Purpose: Type B CRC register, one byte per update
// Assumes: Clear and update never come in the same cycle
// Notes: Holds the raw register; the sender inverts it
`timescale 1ns/100ps
`default_nettype none
`include "tbr_regs.svh"
module tbr_crc (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Control and data
  input wire logic i_clear,
  input wire logic i_en,
  input wire tbr_pkg::tbr_byte_t i_data,
  // Register value
  output logic [15:0] o_crc
);
  import tbr_pkg::*;
  logic [15:0] crc_r;

  // Reflected form, bit zero of the byte first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input tbr_byte_t d);
    logic [15:0] v;
    v = c;
    for (int i = 0; i < 8; i++) begin
      if (v[0] ^ d[i]) begin
        v = (v >> 1) ^ `TBR_CRC_POLY;
      end else begin
        v = v >> 1;
      end
    end
    return v;
  endfunction

  wire [15:0] crc_nxt = i_clear ? `TBR_CRC_PRESET : (i_en ? crc_byte(crc_r, i_data) : crc_r);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      crc_r <= `TBR_CRC_PRESET;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign o_crc = crc_r;
endmodule
`default_nettype wire

/* File: tbr_mem.sv */
// Purpose: Small byte store with registered read data
// Assumes: Words are written well before the other domain reads them
// Notes: Safety across clocks comes from the toggle handshake around it
`timescale 1ns/100ps
`default_nettype none
`include "tbr_regs.svh"
module tbr_mem (
  // Clocks and reset
  input wire logic i_wr_clk,
  input wire logic i_rd_clk,
  input wire logic i_rst_b,
  // Store port
  tbr_mem_if.store bus
);
  import tbr_pkg::*;
  tbr_byte_t mem_r [`TBR_MEM_DEPTH];
  tbr_byte_t rd_data_r;

  always_ff @(posedge i_wr_clk) begin
    if (bus.wr_en) begin
      mem_r[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge i_rd_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= mem_r[bus.rd_addr];
    end
  end

  assign bus.rd_data = rd_data_r;
endmodule
`default_nettype wire

/* File: tbr_mem_if.sv */
// Purpose: Write and read sides of a byte store
// Assumes: Writer and reader may sit in different clock domains
// Notes: Reader sees data one read clock after the address
`timescale 1ns/100ps
`default_nettype none
interface tbr_mem_if;
  import tbr_pkg::*;
  logic wr_en;
  tbr_addr_t wr_addr;
  tbr_byte_t wr_data;
  tbr_addr_t rd_addr;
  tbr_byte_t rd_data;
  modport writer (output wr_en, output wr_addr, output wr_data);
  modport reader (output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: tbr_pkg.sv */
// Purpose: Types of the type B reader codec
// Assumes: tbr_regs.svh holds the numbers
// Notes: Link states are one-hot
package tbr_pkg;
  typedef logic [7:0] tbr_byte_t;
  typedef logic [3:0] tbr_addr_t;
  typedef logic [4:0] tbr_len_t;
  typedef enum logic [12:0] {
    L_IDLE      = 13'h0001,
    L_TX_SOF_LO = 13'h0002,
    L_TX_SOF_HI = 13'h0004,
    L_TX_CHAR   = 13'h0008,
    L_TX_EOF    = 13'h0010,
    L_GUARD     = 13'h0020,
    L_WAIT_SYNC = 13'h0040,
    L_RX_SOF_LO = 13'h0080,
    L_RX_SOF_HI = 13'h0100,
    L_RX_WAIT   = 13'h0200,
    L_RX_CHAR   = 13'h0400,
    L_TURN      = 13'h0800,
    L_SPARE     = 13'h1000
  } tbr_link_st_t;
endpackage

/* File: tbr_reader.sv */
// Purpose: Reader-side frame codec for a type B contactless tag
// Assumes: Link clock is the carrier; front end gives subcarrier and phase bit
// Notes: Half duplex; one CRC register serves both directions
// Overview of operation
// - Reader sends 10% ASK requests, 106 kbit/s
// - Every byte travels as 10-bit character
// - One bit lasts one ETU
// - Start bit 0, eight bits LSB first, stop 1
// - Request SOF: 10 ETU low, 2-3 high
// - Request EOF: 10 ETU low, then rise
// - Guard time of 128 subcarrier periods
// - Reader waits turnaround before next request
// - CRC register preset to all ones
// - Two CRC bytes before EOF, every frame
// - CRC low byte first, LSB first
// - Reader should check answer CRC
`timescale 1ns/100ps
`default_nettype none
`include "tbr_regs.svh"
module tbr_reader #(
  parameter logic [15:0] ANSWER_TIMEOUT_CYC = 16'h4000
) (
  // System clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Request bytes
  input wire logic i_tx_valid,
  input wire tbr_pkg::tbr_byte_t i_tx_data,
  output logic o_tx_ready,
  input wire logic i_send,
  output logic o_busy,
  // Answer status and bytes
  output logic o_done,
  output logic o_ok,
  output logic o_crc_err,
  output logic o_frame_err,
  output logic o_timeout,
  output tbr_pkg::tbr_len_t o_rx_len,
  input wire tbr_pkg::tbr_addr_t i_rx_addr,
  output tbr_pkg::tbr_byte_t o_rx_data,
  // Link to the analog front end
  input wire logic i_link_clk,
  output logic o_ask_mod,
  input wire logic i_sub_on,
  input wire logic i_bpsk_bit
);
  import tbr_pkg::*;

  tbr_mem_if tx_if ();
  tbr_mem_if rx_if ();

  // ---------------- System domain ----------------
  tbr_len_t tx_cnt_r;
  logic busy_r, start_tgl_r, done_r;
  logic done_s1, done_s2, done_s3;
  logic ok_r, crc_err_r, frm_err_r, tmo_r;
  tbr_len_t rx_len_q_r;
  logic done_tgl_r;
  logic stat_ok_r, stat_crc_r, stat_frm_r, stat_to_r;
  tbr_len_t rx_len_r;

  wire tx_push = i_tx_valid && o_tx_ready;
  wire send_go = i_send && !busy_r && (tx_cnt_r != 5'h00);
  wire done_evt = done_s2 ^ done_s3;

  assign o_tx_ready = !busy_r && (tx_cnt_r < 5'(`TBR_MEM_DEPTH));
  assign tx_if.wr_en = tx_push;
  assign tx_if.wr_addr = tx_cnt_r[`TBR_ADDR_W-1:0];
  assign tx_if.wr_data = i_tx_data;
  assign rx_if.rd_addr = i_rx_addr;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_cnt_r <= 5'h00;
      busy_r <= 1'b0;
      start_tgl_r <= 1'b0;
      {done_s1, done_s2, done_s3} <= 3'h0;
      done_r <= 1'b0;
    end else begin
      tx_cnt_r <= done_evt ? 5'h00 : (tx_push ? tx_cnt_r + 5'h01 : tx_cnt_r);
      busy_r <= send_go | (busy_r & ~done_evt);
      start_tgl_r <= start_tgl_r ^ send_go;
      {done_s1, done_s2, done_s3} <= {done_tgl_r, done_s1, done_s2};
      done_r <= done_evt;
    end
  end

  // Link status is frozen from its toggle until the next start, so it is safe here
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {ok_r, crc_err_r, frm_err_r, tmo_r} <= 4'h0;
      rx_len_q_r <= 5'h00;
    end else if (done_evt) begin
      {ok_r, crc_err_r, frm_err_r, tmo_r} <= {stat_ok_r, stat_crc_r, stat_frm_r, stat_to_r};
      rx_len_q_r <= rx_len_r;
    end
  end

  assign o_busy = busy_r;
  assign o_done = done_r;
  assign o_ok = ok_r;
  assign o_crc_err = crc_err_r;
  assign o_frame_err = frm_err_r;
  assign o_timeout = tmo_r;
  assign o_rx_len = rx_len_q_r;
  assign o_rx_data = rx_if.rd_data;

  // ---------------- Link domain ----------------
  tbr_link_st_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [3:0] bcnt_r, bcnt_nxt;
  tbr_len_t idx_r, idx_nxt, rx_len_nxt;
  logic [9:0] sh_r, sh_nxt;
  logic mod_r, mod_nxt;
  logic start_s1, start_s2, start_seen_r, start_seen_nxt;
  logic sub_s1, sub_s2, bit_s1, bit_s2;
  logic done_tgl_nxt;
  logic [3:0] stat_nxt;
  logic crc_clr, crc_en, rx_wr, load, fin;
  tbr_byte_t crc_din;
  logic [15:0] crc_q;

  function automatic logic [9:0] mk_char(input tbr_byte_t b);
    return {1'b1, b, 1'b0};
  endfunction

  wire tick = (cnt_r == 16'h0000);
  wire start_pend = (start_s2 != start_seen_r);
  wire [9:0] char_in = {bit_s2, sh_r[9:1]};
  wire tbr_len_t tx_len = tx_cnt_r;
  wire is_data = (idx_r < tx_len);
  // Inverted register goes out low byte first
  wire tbr_byte_t crc_out = (idx_r == tx_len) ? ~crc_q[7:0] : ~crc_q[15:8];
  wire tbr_byte_t tx_byte = is_data ? tx_if.rd_data : crc_out;
  wire crc_good = (crc_q == `TBR_CRC_RESIDUE) && (rx_len_r >= 5'h02);

  assign tx_if.rd_addr = idx_r[`TBR_ADDR_W-1:0];
  assign rx_if.wr_en = rx_wr;
  assign rx_if.wr_addr = rx_len_r[`TBR_ADDR_W-1:0];
  assign rx_if.wr_data = char_in[8:1];

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = tick ? cnt_r : cnt_r - 16'h0001;
    bcnt_nxt = bcnt_r;
    idx_nxt = idx_r;
    rx_len_nxt = rx_len_r;
    sh_nxt = sh_r;
    mod_nxt = mod_r;
    start_seen_nxt = start_seen_r;
    done_tgl_nxt = done_tgl_r;
    stat_nxt = {stat_ok_r, stat_crc_r, stat_frm_r, stat_to_r};
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_din = tx_byte;
    rx_wr = 1'b0;
    load = 1'b0;
    fin = 1'b0;
    case (st_r)
      L_IDLE: begin
        if (start_pend) begin
          start_seen_nxt = start_s2;
          crc_clr = 1'b1;
          idx_nxt = 5'h00;
          stat_nxt = 4'h0;
          mod_nxt = 1'b1;
          cnt_nxt = 16'(`TBR_SOF_LO_CYC - 1);
          st_nxt = L_TX_SOF_LO;
        end
      end
      L_TX_SOF_LO: begin
        if (tick) begin
          mod_nxt = 1'b0;
          cnt_nxt = 16'(`TBR_SOF_HI_CYC - 1);
          st_nxt = L_TX_SOF_HI;
        end
      end
      L_TX_SOF_HI: begin
        load = tick;
      end
      L_TX_CHAR: begin
        if (tick) begin
          if (bcnt_r == `TBR_CHAR_LAST) begin
            if (idx_r == tx_len + 5'h02) begin
              mod_nxt = 1'b1;
              cnt_nxt = 16'(`TBR_EOF_LO_CYC - 1);
              st_nxt = L_TX_EOF;
            end else begin
              load = 1'b1;
            end
          end else begin
            sh_nxt = {1'b1, sh_r[9:1]};
            mod_nxt = !sh_r[1];
            bcnt_nxt = bcnt_r + 4'h1;
            cnt_nxt = 16'(`TBR_ETU_CYC - 1);
          end
        end
      end
      L_TX_EOF: begin
        if (tick) begin
          mod_nxt = 1'b0;
          cnt_nxt = 16'(`TBR_GUARD_CYC - 1);
          st_nxt = L_GUARD;
        end
      end
      L_GUARD: begin
        // Subcarrier seen before the guard ends is not an answer yet
        if (tick) begin
          crc_clr = 1'b1;
          rx_len_nxt = 5'h00;
          cnt_nxt = ANSWER_TIMEOUT_CYC;
          st_nxt = L_WAIT_SYNC;
        end
      end
      L_WAIT_SYNC: begin
        if (sub_s2 && !bit_s2) begin
          bcnt_nxt = 4'h0;
          cnt_nxt = 16'(`TBR_HALF_ETU_CYC - 1);
          st_nxt = L_RX_SOF_LO;
        end else if (tick) begin
          stat_nxt = 4'h1;
          fin = 1'b1;
        end
      end
      L_RX_SOF_LO: begin
        if (tick) begin
          if (bit_s2) begin
            stat_nxt = 4'h2;
            fin = 1'b1;
          end else if (bcnt_r == `TBR_SOF_LAST) begin
            cnt_nxt = 16'(`TBR_GAP_CYC - 1);
            st_nxt = L_RX_SOF_HI;
          end else begin
            bcnt_nxt = bcnt_r + 4'h1;
            cnt_nxt = 16'(`TBR_ETU_CYC - 1);
          end
        end
      end
      L_RX_SOF_HI: begin
        if (bit_s2) begin
          cnt_nxt = 16'(`TBR_GAP_CYC - 1);
          st_nxt = L_RX_WAIT;
        end else if (tick) begin
          stat_nxt = 4'h2;
          fin = 1'b1;
        end
      end
      L_RX_WAIT: begin
        if (!bit_s2) begin
          bcnt_nxt = 4'h0;
          cnt_nxt = 16'(`TBR_HALF_ETU_CYC - 1);
          st_nxt = L_RX_CHAR;
        end else if (tick) begin
          stat_nxt = 4'h2;
          fin = 1'b1;
        end
      end
      L_RX_CHAR: begin
        if (tick) begin
          sh_nxt = char_in;
          if (bcnt_r == 4'h0 && bit_s2) begin
            stat_nxt = 4'h2;
            fin = 1'b1;
          end else if (bcnt_r == `TBR_CHAR_LAST) begin
            if (char_in[9]) begin
              if (rx_len_r == 5'(`TBR_MEM_DEPTH)) begin
                stat_nxt = 4'h2;
                fin = 1'b1;
              end else begin
                rx_wr = 1'b1;
                crc_en = 1'b1;
                crc_din = char_in[8:1];
                rx_len_nxt = rx_len_r + 5'h01;
                cnt_nxt = 16'(`TBR_GAP_CYC - 1);
                st_nxt = L_RX_WAIT;
              end
            end else if (char_in[8:1] == 8'h00) begin
              stat_nxt = crc_good ? 4'h8 : 4'h4;
              fin = 1'b1;
            end else begin
              stat_nxt = 4'h2;
              fin = 1'b1;
            end
          end else begin
            bcnt_nxt = bcnt_r + 4'h1;
            cnt_nxt = 16'(`TBR_ETU_CYC - 1);
          end
        end
      end
      L_TURN: begin
        if (tick) begin
          st_nxt = L_IDLE;
        end
      end
      default: begin
        st_nxt = L_IDLE;
      end
    endcase
    if (load) begin
      sh_nxt = mk_char(tx_byte);
      mod_nxt = 1'b1;
      bcnt_nxt = 4'h0;
      cnt_nxt = 16'(`TBR_ETU_CYC - 1);
      idx_nxt = idx_r + 5'h01;
      crc_en = is_data;
      st_nxt = L_TX_CHAR;
    end
    if (fin) begin
      done_tgl_nxt = !done_tgl_r;
      cnt_nxt = 16'(`TBR_TURN_CYC - 1);
      st_nxt = L_TURN;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {start_s1, start_s2, sub_s1, sub_s2, bit_s1, bit_s2} <= 6'h00;
    end else begin
      {start_s1, start_s2} <= {start_tgl_r, start_s1};
      {sub_s1, sub_s2} <= {i_sub_on, sub_s1};
      {bit_s1, bit_s2} <= {i_bpsk_bit, bit_s1};
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= L_IDLE;
      cnt_r <= 16'h0000;
      bcnt_r <= 4'h0;
      idx_r <= 5'h00;
      rx_len_r <= 5'h00;
      sh_r <= 10'h000;
      mod_r <= 1'b0;
      start_seen_r <= 1'b0;
      done_tgl_r <= 1'b0;
      {stat_ok_r, stat_crc_r, stat_frm_r, stat_to_r} <= 4'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bcnt_r <= bcnt_nxt;
      idx_r <= idx_nxt;
      rx_len_r <= rx_len_nxt;
      sh_r <= sh_nxt;
      mod_r <= mod_nxt;
      start_seen_r <= start_seen_nxt;
      done_tgl_r <= done_tgl_nxt;
      {stat_ok_r, stat_crc_r, stat_frm_r, stat_to_r} <= stat_nxt;
    end
  end

  assign o_ask_mod = mod_r;

  tbr_crc u_crc (
    .i_clk(i_link_clk),
    .i_rst_b(i_rst_b),
    .i_clear(crc_clr),
    .i_en(crc_en),
    .i_data(crc_din),
    .o_crc(crc_q)
  );

  tbr_mem u_tx_mem (
    .i_wr_clk(i_sys_clk),
    .i_rd_clk(i_link_clk),
    .i_rst_b(i_rst_b),
    .bus(tx_if.store)
  );

  tbr_mem u_rx_mem (
    .i_wr_clk(i_link_clk),
    .i_rd_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .bus(rx_if.store)
  );
endmodule
`default_nettype wire

/* File: tbr_reader_asserts.sv */
// Purpose: Port checker of the type B reader codec
// Assumes: Link clock is the carrier, 128 cycles per bit
// Notes: Run counters measure the modulation in link cycles
`timescale 1ns/100ps
`default_nettype none
module tbr_reader_asserts #(
  parameter logic [15:0] ANSWER_TIMEOUT_CYC = 16'h4000
) (
  // System side
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic i_send,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_ok,
  input wire logic o_crc_err,
  input wire logic o_frame_err,
  input wire logic o_timeout,
  input wire tbr_pkg::tbr_len_t o_rx_len,
  // Link side
  input wire logic i_link_clk,
  input wire logic o_ask_mod
);
  import tbr_pkg::*;
  logic mod_q_r;
  logic [11:0] run_r;
  logic [11:0] lo_last_r;
  logic [4:0] cnt_r;
  wire mod_fell = mod_q_r && !o_ask_mod;
  wire mod_rose = !mod_q_r && o_ask_mod;
  // Reset counts as a long idle, so the first frame is not mistaken for a short gap
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mod_q_r <= 1'b0;
      run_r <= 12'hfff;
      lo_last_r <= 12'h0;
    end else begin
      mod_q_r <= o_ask_mod;
      run_r <= (mod_fell || mod_rose) ? 12'h1 : run_r + {11'h0, run_r != 12'hfff};
      if (mod_fell) begin
        lo_last_r <= run_r;
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 5'h0;
    end else if (o_busy) begin
      // Store empties while busy; the design holds its own count until the done event clears it
      cnt_r <= 5'h0;
    end else if (i_tx_valid && o_tx_ready) begin
      cnt_r <= cnt_r + 5'h1;
    end
  end
  low_run_a:
    assert property (@(posedge i_link_clk) disable iff (!i_rst_b) mod_fell |->
      run_r[6:0] == 7'h0 && run_r != 12'h0 && run_r <= 12'h500) else $error("bad low run");
  high_run_a:
    assert property (@(posedge i_link_clk) disable iff (!i_rst_b) mod_rose && run_r < 12'h800
      |-> run_r[6:0] == 7'h0 && run_r != 12'h0) else $error("bad high run");
  sof_high_a:
    assert property (@(posedge i_link_clk) disable iff (!i_rst_b) mod_rose && lo_last_r == 12'h500
      |-> (run_r >= 12'h100 && run_r <= 12'h180) || run_r >= 12'h800) else $error("bad sof gap");
  done_pulse_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_done |=> !o_done)
      else $error("done too long");
  done_flags_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      o_done |-> $onehot({o_ok, o_crc_err, o_frame_err, o_timeout})) else $error("flags");
  ok_len_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      o_done && o_ok |-> o_rx_len >= 5'h2 && o_rx_len <= 5'h10) else $error("bad length");
  busy_ready_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_busy |-> !o_tx_ready)
      else $error("ready while busy");
  send_start_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      i_send && !o_busy && cnt_r != 5'h0 |=> o_busy) else $error("send lost");
endmodule
bind tbr_reader tbr_reader_asserts #(.ANSWER_TIMEOUT_CYC(ANSWER_TIMEOUT_CYC)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
  .i_send(i_send), .o_busy(o_busy), .o_done(o_done), .o_ok(o_ok), .o_crc_err(o_crc_err),
  .o_frame_err(o_frame_err), .o_timeout(o_timeout), .o_rx_len(o_rx_len),
  .i_link_clk(i_link_clk), .o_ask_mod(o_ask_mod));
`default_nettype wire

/* File: tbr_regs.svh */
// Purpose: Timing counts, CRC constants and sizes of the type B reader codec
// Assumes: Link clock runs at the 13.56 MHz carrier rate
// Notes: Counts are in link clock cycles
`ifndef TBR_REGS_SVH
`define TBR_REGS_SVH

`define TBR_LINK_KHZ 13560
`define TBR_ETU_NS 9440
`define TBR_ETU_CYC ((`TBR_ETU_NS * `TBR_LINK_KHZ) / 1000000)
`define TBR_HALF_ETU_CYC (`TBR_ETU_CYC / 2)
`define TBR_SUB_PER_ETU 8
`define TBR_SUB_CYC (`TBR_ETU_CYC / `TBR_SUB_PER_ETU)
`define TBR_SOF_LO_ETU 10
`define TBR_SOF_HI_ETU 2
`define TBR_EOF_LO_ETU 10
`define TBR_SOF_LO_CYC (`TBR_SOF_LO_ETU * `TBR_ETU_CYC)
`define TBR_SOF_HI_CYC (`TBR_SOF_HI_ETU * `TBR_ETU_CYC)
`define TBR_EOF_LO_CYC (`TBR_EOF_LO_ETU * `TBR_ETU_CYC)
`define TBR_GUARD_SUB 128
`define TBR_GUARD_CYC (`TBR_GUARD_SUB * `TBR_SUB_CYC)
`define TBR_GAP_ETU 4
`define TBR_GAP_CYC (`TBR_GAP_ETU * `TBR_ETU_CYC)
`define TBR_TURN_ETU 8
`define TBR_TURN_CYC (`TBR_TURN_ETU * `TBR_ETU_CYC)
`define TBR_CHAR_LAST 4'h9
`define TBR_SOF_LAST 4'h9
`define TBR_CRC_PRESET 16'hffff
`define TBR_CRC_POLY 16'h8408
`define TBR_CRC_RESIDUE 16'hf0b8
`define TBR_MEM_DEPTH 16
`define TBR_ADDR_W 4

`endif

/* File: tbr_tag_model.sv */
// Purpose: Behavioural tag on the far side of the reader codec
// Assumes: Input is the reader modulation; link clock is the carrier
// Notes: Answers echo the request payload; mode 1 spoils the CRC, mode 2 stays silent,
// mode 3 breaks the first stop bit
`timescale 1ns/100ps
`default_nettype none
module tbr_tag_model (
  // Link
  input wire logic i_clk,
  input wire logic i_mod,
  output logic o_sub_on,
  output logic o_bpsk_bit,
  // Control and status
  input wire logic [1:0] i_mode,
  output logic o_req_ok,
  output logic o_turn_ok,
  output int o_rx_n
);
  logic [7:0] pay [0:31];
  logic [9:0] s;
  logic [15:0] crc;
  logic ok;
  logic bit_r = 1'b1;
  logic tog_r = 1'b0;
  int cyc = 0;
  int eof_c = -4096;
  // Without subcarrier the bit line flips, so nobody can lean on a stale level
  assign o_bpsk_bit = o_sub_on ? bit_r : tog_r;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    tog_r <= ~tog_r;
  end
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h0, d};
    for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ 16'h8408 : r >> 1;
    return r;
  endfunction
  task automatic send(input logic v, input int e);
    bit_r <= v;
    repeat (128 * e) @(posedge i_clk);
  endtask
  task automatic send_byte(input logic [7:0] b, input logic stop);
    send(1'b0, 1);
    for (int i = 0; i < 8; i++) send(b[i], 1);
    send(stop, 1);
  endtask
  initial begin
    o_sub_on = 1'b0;
    o_req_ok = 1'b0;
    o_turn_ok = 1'b0;
    o_rx_n = 0;
    forever begin
      while (!i_mod) @(posedge i_clk);
      o_turn_ok = cyc - eof_c >= 1024;
      o_rx_n = 0;
      repeat (640) @(posedge i_clk);
      ok = i_mod;
      while (i_mod) @(posedge i_clk);
      while (1) begin
        while (!i_mod) @(posedge i_clk);
        repeat (64) @(posedge i_clk);
        for (int k = 0; k < 10; k++) begin
          s[k] = i_mod;
          if (k < 9) repeat (128) @(posedge i_clk);
        end
        if (&s) break;
        ok = ok && s[0] && !s[9];
        pay[o_rx_n] = ~s[8:1];
        o_rx_n++;
      end
      while (i_mod) @(posedge i_clk);
      crc = 16'hffff;
      for (int k = 0; k < o_rx_n; k++) crc = crc_upd(crc, pay[k]);
      o_req_ok = ok && o_rx_n >= 2 && crc == 16'hf0b8;
      if (o_req_ok && i_mode != 2'h2) begin
        repeat (2048) @(posedge i_clk);
        o_sub_on <= 1'b1;
        send(1'b1, 16);
        send(1'b0, 10);
        send(1'b1, 2);
        crc = 16'hffff;
        for (int k = 0; k < o_rx_n - 2; k++) begin
          send_byte(pay[k], !(i_mode == 2'h3 && k == 0));
          crc = crc_upd(crc, pay[k]);
        end
        crc = ~crc ^ {15'h0, i_mode == 2'h1};
        send_byte(crc[7:0], 1'b1);
        send_byte(crc[15:8], 1'b1);
        eof_c = cyc;
        send(1'b0, 10);
        send(1'b1, 2);
        o_sub_on <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
